// [hw/ofpd_map.svh]
// Register offsets, field positions and reset values of the output configuration block.
`ifndef OFPD_MAP_SVH
`define OFPD_MAP_SVH

// Register offsets on the serial control port.
`define OFPD_OFS_B_DRV 8'h1f
`define OFPD_OFS_B_SE 8'h20
`define OFPD_OFS_C_DIV_LO 8'h21
`define OFPD_OFS_C_DIV_HI 8'h22
`define OFPD_OFS_C_PH_LO 8'h23
`define OFPD_OFS_C_PH_HI 8'h24

// Field positions in the second output driver register.
`define OFPD_B_PD_BIT 7
`define OFPD_B_SYNCX_BIT 6
`define OFPD_B_POL_HI 5
`define OFPD_B_POL_LO 4
`define OFPD_B_KIND_HI 3
`define OFPD_B_KIND_LO 1

// Field positions in the second output single-ended register.
`define OFPD_B_TEN_BIT 7
`define OFPD_B_TPOL_HI 6
`define OFPD_B_TPOL_LO 5
`define OFPD_B_CEN_BIT 4
`define OFPD_B_CPOL_HI 3
`define OFPD_B_CPOL_LO 2

// Upper field positions of the third output ratio and phase.
`define OFPD_C_DIV_HI_MSB 1
`define OFPD_C_PH_HI_MSB 2

// Reset values.
`define OFPD_RST_B_POL 2'h1
`define OFPD_RST_B_KIND 3'h2
`define OFPD_RST_SE_POL 2'h0
`define OFPD_RST_C_DIV 10'h000
`define OFPD_RST_C_PH 11'h000

`endif

// [hw/ofpd_pkg.sv]
// Types shared by the output configuration block.
package ofpd_pkg;

  // Four-way polarity coding used by differential and single-ended drivers.
  typedef enum logic [1:0] {
    OFPD_POL_HIGH = 2'h0,
    OFPD_POL_TRUE = 2'h1,
    OFPD_POL_INV = 2'h2,
    OFPD_POL_LOW = 2'h3
  } ofpd_pol_t;

  // Driver kinds of the second output.
  typedef enum logic [2:0] {
    OFPD_KIND_LV_HALF = 3'h0,
    OFPD_KIND_LV_3Q = 3'h1,
    OFPD_KIND_LV_FULL = 3'h2,
    OFPD_KIND_LV_BIG = 3'h3,
    OFPD_KIND_HS_STD = 3'h4,
    OFPD_KIND_HS_BOOST = 3'h5,
    OFPD_KIND_SE_A = 3'h6,
    OFPD_KIND_SE_B = 3'h7
  } ofpd_kind_t;

endpackage

// [hw/ofpd_div_if.sv]
// Signals between the configuration top and the third output divider.
`timescale 1ns/1ns
interface ofpd_div_if;
  logic [9:0] divide_value;
  logic [10:0] phase_value;
  logic sync_pulse;
  logic clk_out;

  modport cfg (output divide_value, output phase_value, output sync_pulse, input clk_out);
  modport div (input divide_value, input phase_value, input sync_pulse, output clk_out);
endinterface

// [hw/ofpd_divider.sv]
// Third output divider with half-period phase offset.
`timescale 1ns/1ns
`include "ofpd_map.svh"
module ofpd_divider
  import ofpd_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  ofpd_div_if.div dif
);

  typedef enum logic {OFPD_ST_DELAY, OFPD_ST_RUN} ofpd_dst_t;

  ofpd_dst_t state_q;
  logic [9:0] cnt_q;
  logic [9:0] delay_q;
  logic pos_q;
  logic neg_q;
  wire logic [10:0] high_len;
  wire logic bypass;
  wire logic period_end;
  wire logic pos_d;

  // High time is the larger half, so even ratios, which give odd periods, lean high by one cycle.
  assign high_len = ({1'b0, dif.divide_value} + 11'h0002) >> 1;
  assign bypass = (dif.divide_value == 10'h000);
  assign period_end = (cnt_q >= dif.divide_value);
  // A sync forces the output low at once, so no stale high pulse precedes the delay.
  assign pos_d = (state_q == OFPD_ST_RUN) && !dif.sync_pulse && ({1'b0, cnt_q} < high_len);

  // Whole periods of delay are counted here; the odd half is added by the falling edge.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= OFPD_ST_RUN;
      cnt_q <= 10'h000;
      delay_q <= 10'h000;
      pos_q <= 1'b0;
    end else begin
      pos_q <= pos_d;
      case (state_q)
        OFPD_ST_RUN: begin
          if (dif.sync_pulse) begin
            state_q <= OFPD_ST_DELAY;
            delay_q <= dif.phase_value[10:1];
            cnt_q <= 10'h000;
          end else if (period_end) begin
            cnt_q <= 10'h000;
          end else begin
            cnt_q <= cnt_q + 10'h001;
          end
        end
        OFPD_ST_DELAY: begin
          if (delay_q == 10'h000) begin
            state_q <= OFPD_ST_RUN;
          end else begin
            delay_q <= delay_q - 10'h001;
          end
        end
        default: begin
          state_q <= OFPD_ST_RUN;
        end
      endcase
    end
  end

  // Falling-edge copy gives the half input period step.
  always_ff @(negedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      neg_q <= 1'b0;
    end else begin
      neg_q <= pos_q;
    end
  end

  // Divide-by-one passes the input clock itself, inverted for an odd half step.
  assign dif.clk_out = bypass ?
    ((state_q == OFPD_ST_RUN) && (dif.phase_value[0] ? !clock_in : clock_in)) :
    (dif.phase_value[0] ? neg_q : pos_q);

endmodule

// [hw/ofpd_cfg_top.sv]
// Second output driver control and third output divider configuration.
// Function
// - The third output divider divides the input clock by its 10-bit ratio plus one.
// - The ratio takes eight low bits from one register and bits 1:0 of register 0x22.
// - The third output is delayed by its 11-bit phase value in half input periods.
// - The phase takes eight low bits from one register and bits 2:0 of register 0x24.
// - Bit 6 of the second driver register excludes its divider from sync, bit 7 powers it down.
// - Bits 5:4 pick force high, pass, invert or force low for the differential driver.
// - Bits 3:1 pick four low-swing levels, two high-speed levels or off with single-ended use.
// - Bit 7 of register out_b_single_ended_ctrl enables the true-side single-ended driver, default off.
// - Bits 6:5 give the true-side polarity with the same coding, default force high.
// - Bit 4 of register out_b_single_ended_ctrl enables the complement-side single-ended driver, default off.
// - Bits 3:2 give the complement-side polarity, default force high.
`timescale 1ns/1ns
`include "ofpd_map.svh"
module ofpd_cfg_top
  import ofpd_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic sync_in,
  input wire logic div_b_clk_in,
  output logic div_b_powerdown_out,
  output logic div_b_sync_exclude_out,
  output logic [2:0] out_b_driver_kind_out,
  output logic out_b_diff_out,
  output logic out_b_diff_oe_out,
  output logic out_b_true_se_out,
  output logic out_b_true_se_oe_out,
  output logic out_b_comp_se_out,
  output logic out_b_comp_se_oe_out,
  output logic [9:0] out_c_divide_value_out,
  output logic [10:0] out_c_phase_value_out,
  output logic third_clock_output_out
);

  // Second output driver register fields.
  logic div_b_powerdown_q;
  logic div_b_sync_exclude_q;
  ofpd_pol_t out_b_polarity_sel_q;
  ofpd_kind_t out_b_driver_kind_q;

  // Second output single-ended fields.
  logic out_b_true_se_enable_q;
  ofpd_pol_t out_b_true_se_polarity_q;
  logic out_b_comp_se_enable_q;
  ofpd_pol_t out_b_comp_se_polarity_q;

  // Third output ratio and phase.
  logic [9:0] out_c_divide_value_q;
  logic [10:0] out_c_phase_value_q;

  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Write decode.
  wire logic wr_b_drv;
  wire logic wr_b_se;
  wire logic wr_c_div_lo;
  wire logic wr_c_div_hi;
  wire logic wr_c_ph_lo;
  wire logic wr_c_ph_hi;

  assign wr_b_drv = reg_wr_in && (reg_addr_in == `OFPD_OFS_B_DRV);
  assign wr_b_se = reg_wr_in && (reg_addr_in == `OFPD_OFS_B_SE);
  assign wr_c_div_lo = reg_wr_in && (reg_addr_in == `OFPD_OFS_C_DIV_LO);
  assign wr_c_div_hi = reg_wr_in && (reg_addr_in == `OFPD_OFS_C_DIV_HI);
  assign wr_c_ph_lo = reg_wr_in && (reg_addr_in == `OFPD_OFS_C_PH_LO);
  assign wr_c_ph_hi = reg_wr_in && (reg_addr_in == `OFPD_OFS_C_PH_HI);

  // Readback images; only field bits are stored, so reserved bits are zero.
  wire logic [7:0] img_b_drv;
  wire logic [7:0] img_b_se;
  wire logic [7:0] img_c_div_hi;
  wire logic [7:0] img_c_ph_hi;

  assign img_b_drv = {div_b_powerdown_q, div_b_sync_exclude_q, out_b_polarity_sel_q,
                      out_b_driver_kind_q, 1'b0};
  assign img_b_se = {out_b_true_se_enable_q, out_b_true_se_polarity_q,
                     out_b_comp_se_enable_q, out_b_comp_se_polarity_q, 2'h0};
  assign img_c_div_hi = {6'h00, out_c_divide_value_q[9:8]};
  assign img_c_ph_hi = {5'h00, out_c_phase_value_q[10:8]};

  // Read select; an unmapped offset returns zero.
  always_comb begin
    case (reg_addr_in)
      `OFPD_OFS_B_DRV: rdata_d = img_b_drv;
      `OFPD_OFS_B_SE: rdata_d = img_b_se;
      `OFPD_OFS_C_DIV_LO: rdata_d = out_c_divide_value_q[7:0];
      `OFPD_OFS_C_DIV_HI: rdata_d = img_c_div_hi;
      `OFPD_OFS_C_PH_LO: rdata_d = out_c_phase_value_q[7:0];
      `OFPD_OFS_C_PH_HI: rdata_d = img_c_ph_hi;
      default: rdata_d = 8'h00;
    endcase
  end

  // Second output driver register.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_b_powerdown_q <= 1'b0;
      div_b_sync_exclude_q <= 1'b0;
      out_b_polarity_sel_q <= ofpd_pol_t'(`OFPD_RST_B_POL);
      out_b_driver_kind_q <= ofpd_kind_t'(`OFPD_RST_B_KIND);
    end else if (wr_b_drv) begin
      div_b_powerdown_q <= reg_wdata_in[`OFPD_B_PD_BIT];
      div_b_sync_exclude_q <= reg_wdata_in[`OFPD_B_SYNCX_BIT];
      out_b_polarity_sel_q <= ofpd_pol_t'(reg_wdata_in[`OFPD_B_POL_HI:`OFPD_B_POL_LO]);
      out_b_driver_kind_q <= ofpd_kind_t'(reg_wdata_in[`OFPD_B_KIND_HI:`OFPD_B_KIND_LO]);
    end
  end

  // Second output single-ended register.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      out_b_true_se_enable_q <= 1'b0;
      out_b_true_se_polarity_q <= ofpd_pol_t'(`OFPD_RST_SE_POL);
      out_b_comp_se_enable_q <= 1'b0;
      out_b_comp_se_polarity_q <= ofpd_pol_t'(`OFPD_RST_SE_POL);
    end else if (wr_b_se) begin
      out_b_true_se_enable_q <= reg_wdata_in[`OFPD_B_TEN_BIT];
      out_b_true_se_polarity_q <=
        ofpd_pol_t'(reg_wdata_in[`OFPD_B_TPOL_HI:`OFPD_B_TPOL_LO]);
      out_b_comp_se_enable_q <= reg_wdata_in[`OFPD_B_CEN_BIT];
      out_b_comp_se_polarity_q <=
        ofpd_pol_t'(reg_wdata_in[`OFPD_B_CPOL_HI:`OFPD_B_CPOL_LO]);
    end
  end

  // Ratio and phase halves; each byte updates on its own, so software
  // should write both halves before a sync to avoid a mixed value.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      out_c_divide_value_q <= `OFPD_RST_C_DIV;
      out_c_phase_value_q <= `OFPD_RST_C_PH;
    end else begin
      if (wr_c_div_lo) begin
        out_c_divide_value_q[7:0] <= reg_wdata_in;
      end
      if (wr_c_div_hi) begin
        out_c_divide_value_q[9:8] <= reg_wdata_in[`OFPD_C_DIV_HI_MSB:0];
      end
      if (wr_c_ph_lo) begin
        out_c_phase_value_q[7:0] <= reg_wdata_in;
      end
      if (wr_c_ph_hi) begin
        out_c_phase_value_q[10:8] <= reg_wdata_in[`OFPD_C_PH_HI_MSB:0];
      end
    end
  end

  // Read data is registered one cycle after the read strobe and holds until the next read.
  // A read in the cycle of a write to the same offset returns the old value.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_in) begin
      rdata_q <= rdata_d;
    end
  end

  // Codes 110 and 111 turn the differential stage off in favour of single-ended use.
  wire logic se_mode;
  wire logic div_b_clk_live;
  assign se_mode = out_b_driver_kind_q[2] && out_b_driver_kind_q[1];
  // A powered-down divider is held low so the drivers see a still clock.
  assign div_b_clk_live = div_b_clk_in && !div_b_powerdown_q;

  // Polarity code per driver: 0 differential, 1 true side, 2 complement side.
  wire logic [1:0] drv_pol [3];
  wire logic [2:0] drv_data;
  assign drv_pol[0] = out_b_polarity_sel_q;
  assign drv_pol[1] = out_b_true_se_polarity_q;
  assign drv_pol[2] = out_b_comp_se_polarity_q;

  // The same four-way coding serves all three drivers, so one loop builds them.
  generate
    for (genvar g = 0; g < 3; g++) begin : g_pol
      assign drv_data[g] = (drv_pol[g] == OFPD_POL_HIGH) ? 1'b1 :
        (drv_pol[g] == OFPD_POL_TRUE) ? div_b_clk_live :
        (drv_pol[g] == OFPD_POL_INV) ? !div_b_clk_live : 1'b0;
    end
  endgenerate

  // Second output drivers; the drive level itself lives in the analog pad, so only
  // the data and the enables are made here.
  assign out_b_diff_out = drv_data[0];
  assign out_b_diff_oe_out = !se_mode;
  assign out_b_true_se_out = drv_data[1];
  assign out_b_true_se_oe_out = se_mode && out_b_true_se_enable_q;
  assign out_b_comp_se_out = drv_data[2];
  assign out_b_comp_se_oe_out = se_mode && out_b_comp_se_enable_q;

  // Configuration visible to the second divider and the sync logic.
  assign div_b_powerdown_out = div_b_powerdown_q;
  assign div_b_sync_exclude_out = div_b_sync_exclude_q;
  assign out_b_driver_kind_out = out_b_driver_kind_q;
  assign out_c_divide_value_out = out_c_divide_value_q;
  assign out_c_phase_value_out = out_c_phase_value_q;
  assign reg_rdata_out = rdata_q;

  // Third output divider.
  ofpd_div_if dif ();
  assign dif.divide_value = out_c_divide_value_q;
  assign dif.phase_value = out_c_phase_value_q;
  // The sync pulse comes from the global sync logic on this same clock, so it needs no synchroniser.
  assign dif.sync_pulse = sync_in;

  ofpd_divider u_div (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .dif(dif.div)
  );

  assign third_clock_output_out = dif.clk_out;

endmodule

// [tb/ofpd_cfg_asserts.sv]
// Concurrent checks on the ports of the output configuration block.
`timescale 1ns/1ns
module ofpd_cfg_asserts (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic div_b_powerdown_out,
  input wire logic div_b_sync_exclude_out,
  input wire logic [2:0] out_b_driver_kind_out,
  input wire logic out_b_diff_oe_out,
  input wire logic [9:0] out_c_divide_value_out,
  input wire logic [10:0] out_c_phase_value_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // A write strobe at one offset; its effect is due right after that edge.
  sequence s_wr(logic [7:0] ofs);
    reg_wr_in && reg_addr_in == ofs;
  endsequence
  a_div_lo: assert property (
    s_wr(8'h21) |=> out_c_divide_value_out[7:0] == $past(reg_wdata_in))
    else $error("Divide low byte lost.");
  a_div_hi: assert property (
    s_wr(8'h22) |=> out_c_divide_value_out[9:8] == $past(reg_wdata_in[1:0]))
    else $error("Divide high bits lost.");
  a_ph_lo: assert property (
    s_wr(8'h23) |=> out_c_phase_value_out[7:0] == $past(reg_wdata_in))
    else $error("Phase low byte lost.");
  a_ph_hi: assert property (
    s_wr(8'h24) |=> out_c_phase_value_out[10:8] == $past(reg_wdata_in[2:0]))
    else $error("Phase high bits lost.");
  a_drv_fields: assert property (s_wr(8'h1f) |=>
    {div_b_powerdown_out, div_b_sync_exclude_out, out_b_driver_kind_out} ==
    {$past(reg_wdata_in[7:6]), $past(reg_wdata_in[3:1])}) else $error("Driver fields lost.");
  a_diff_oe: assert property (
    out_b_diff_oe_out == (out_b_driver_kind_out[2:1] != 2'b11))
    else $error("Differential enable disagrees with kind.");
  a_rd_unmapped: assert property (
    reg_rd_in && (reg_addr_in < 8'h1f || reg_addr_in > 8'h24) |=> reg_rdata_out == 8'h00)
    else $error("Unmapped read not zero.");
  a_fields_hold: assert property (!reg_wr_in |=>
    $stable(out_c_divide_value_out) && $stable(out_c_phase_value_out))
    else $error("Ratio or phase moved without a write.");
endmodule

// [tb/ofpd_clk_sink.sv]
// Downstream receiver model that times the third clock output.
`timescale 1ns/1ns
module ofpd_clk_sink (
  input wire logic rx_clk_in,
  output logic [31:0] period_out,
  output logic [31:0] high_out
);
  realtime rise_q = 0.0;
  // Timed in real time, since a divide-by-one output moves with the clock edge itself.
  always @(posedge rx_clk_in) begin
    period_out = 32'(int'($realtime - rise_q));
    rise_q = $realtime;
  end
  // High time of the latest pulse.
  always @(negedge rx_clk_in) begin
    high_out = 32'(int'($realtime - rise_q));
  end
endmodule

// [tb/ofpd_cfg_top_bench.sv]
// Self-checking bench for the output configuration block.
`timescale 1ns/1ns
module ofpd_cfg_top_bench;
  import ofpd_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, sync = 1'b0, bclk = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, a;
  logic [2:0] kind;
  logic diff, doe, tse, toe, cse, coe, cout, pd, sx;
  logic [9:0] divv;
  logic [10:0] phv;
  logic [31:0] period, high;
  logic [7:0] sh [256];
  int bad_count = 0, cmp_count = 0;
  int rt[5] = '{0, 1, 2, 5, 1023};
  int ph[5] = '{0, 1, 2, 7, 2047};
  realtime t0, d, d0;

  ofpd_cfg_top uut (
    .clock_in(clk), .rstn_in(rstn), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .sync_in(sync),
    .div_b_clk_in(bclk), .div_b_powerdown_out(pd), .div_b_sync_exclude_out(sx),
    .out_b_driver_kind_out(kind), .out_b_diff_out(diff), .out_b_diff_oe_out(doe),
    .out_b_true_se_out(tse), .out_b_true_se_oe_out(toe), .out_b_comp_se_out(cse),
    .out_b_comp_se_oe_out(coe), .out_c_divide_value_out(divv),
    .out_c_phase_value_out(phv), .third_clock_output_out(cout)
  );
  ofpd_clk_sink sink (.rx_clk_in(cout), .period_out(period), .high_out(high));

  // Free-running 100 MHz clock.
  initial forever #5 clk = ~clk;

  // Implemented bits of each offset; everything else reads zero.
  function automatic logic [7:0] mask(input logic [7:0] ofs);
    case (ofs)
      8'h1f: mask = 8'hfe;
      8'h20: mask = 8'hfc;
      8'h21, 8'h23: mask = 8'hff;
      8'h22: mask = 8'h03;
      8'h24: mask = 8'h07;
      default: mask = 8'h00;
    endcase
  endfunction
  // Expected driver level for a polarity code and a source clock level.
  function automatic logic polf(input logic [1:0] p, input logic c);
    polf = (p == OFPD_POL_HIGH) ? 1'b1 : (p == OFPD_POL_TRUE) ? c : (p == OFPD_POL_INV) ? !c : 1'b0;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One-cycle write strobe, raised and dropped on falling edges.
  task automatic wreg(input logic [7:0] o, input logic [7:0] v);
    @(negedge clk);
    addr = o;
    wdata = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    sh[o] = v;
  endtask
  task automatic rchk(input logic [7:0] o);
    @(negedge clk);
    addr = o;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(rdata, sh[o] & mask(o));
  endtask
  // Sync taken at one edge; it is dropped later so the caller can watch the output at once.
  task automatic pulse;
    @(negedge clk);
    sync = 1'b1;
    @(posedge clk);
    t0 = $realtime;
    fork
      @(negedge clk) sync = 1'b0;
    join_none
  endtask

  // Watchdog sized well above the longest divider run.
  initial begin
    #1_000_000;
    bad_count++;
    summarize;
  end

  initial begin
    void'($urandom(63463));
    foreach (sh[i]) sh[i] = 8'h00;
    sh[8'h1f] = 8'h14;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    for (int i = 8'h1e; i < 8'h26; i++) rchk(8'(i));
    // Random bytes, reserved bits included, must read back masked and assemble the fields.
    repeat (30) begin
      a = 8'h1f + 8'($urandom % 6);
      wreg(a, 8'($urandom));
      rchk(a);
      chk(divv, {sh[8'h22][1:0], sh[8'h21]});
      chk(phv, {sh[8'h24][2:0], sh[8'h23]});
      chk({pd, sx}, sh[8'h1f][7:6]);
    end
    for (int k = 0; k < 8; k++) begin
      wreg(8'h1f, {4'h1, 3'(k), 1'b0});
      chk({kind, doe}, {3'(k), k < 6});
    end
    for (int p = 0; p < 4; p++) begin
      wreg(8'h1f, {2'b00, 2'(p), 3'b010, 1'b0});
      wreg(8'h20, {1'b1, 2'(p), 1'b1, 2'(3 - p), 2'b00});
      for (int c = 0; c < 2; c++) begin
        @(negedge clk);
        bclk = c[0];
        #1;
        chk(diff, polf(2'(p), c[0]));
      end
      wreg(8'h1f, {2'b00, 2'(p), 3'b110, 1'b0});
      bclk = 1'($urandom);
      #1;
      chk({doe, toe, coe}, 3'b011);
      chk(tse, polf(2'(p), bclk));
      chk(cse, polf(2'(3 - p), bclk));
      wreg(8'h20, 8'h00);
      chk({toe, coe}, 2'b00);
    end
    // A powered-down divider shows a still low clock even with a noninverting driver.
    wreg(8'h1f, 8'h94);
    bclk = 1'b1;
    #1;
    chk(diff, 1'b0);
    wreg(8'h23, 8'h00);
    wreg(8'h24, 8'h00);
    foreach (rt[i]) begin
      wreg(8'h21, rt[i][7:0]);
      wreg(8'h22, {6'h00, rt[i][9:8]});
      pulse;
      repeat (3 * rt[i] + 6) @(posedge clk);
      chk(period, 10 * (rt[i] + 1));
      chk(high, rt[i] == 0 ? 5 : 10 * ((rt[i] + 2) / 2));
    end
    wreg(8'h21, 8'h03);
    wreg(8'h22, 8'h00);
    foreach (ph[i]) begin
      wreg(8'h23, ph[i][7:0]);
      wreg(8'h24, {5'h00, ph[i][10:8]});
      pulse;
      @(posedge cout);
      d = $realtime - t0;
      if (i == 0) d0 = d;
      else chk(int'(d - d0), 5 * ph[i]);
    end
    summarize;
  end
endmodule

bind ofpd_cfg_top ofpd_cfg_asserts chk_i (.clock_in(clock_in), .rstn_in(rstn_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .div_b_powerdown_out(div_b_powerdown_out), .div_b_sync_exclude_out(div_b_sync_exclude_out),
  .out_b_driver_kind_out(out_b_driver_kind_out), .out_b_diff_oe_out(out_b_diff_oe_out),
  .out_c_divide_value_out(out_c_divide_value_out),
  .out_c_phase_value_out(out_c_phase_value_out));
